// file: i2c_ctl_pkg.sv
package i2c_ctl_pkg;

	// ==========================================================
	// Register map (byte addresses)
	// ==========================================================
	localparam int          ADDR_W          = 12;
	localparam logic [11:0] MASKED_STS_OFF  = 12'h018; // Read-only view
	localparam logic [11:0] MASTER_CTL_OFF  = 12'h020; // Master control
	localparam logic [11:0] EVT_STS_OFF     = 12'h024; // Sticky events, W1C
	localparam logic [11:0] EVT_MASK_OFF    = 12'h028; // Event mask

	// ==========================================================
	// Masked status field positions
	// ==========================================================
	localparam int CLK_LOW_TMO_BIT    = 25;
	localparam int EVENT_TMO_BIT      = 24;
	localparam int MON_IDLE_BIT       = 19;
	localparam int MON_OVERRUN_BIT    = 17;
	localparam int MON_READY_BIT      = 16;
	localparam int TGT_DESEL_BIT      = 15;
	localparam int TGT_NOSTRETCH_BIT  = 11;
	localparam int TGT_PENDING_BIT    = 8;
	localparam int MST_SS_ERR_BIT     = 6;
	localparam int MST_ARB_LOSS_BIT   = 4;
	localparam int MST_PENDING_BIT    = 0;

	// Implemented bits; reserved positions read as zero
	localparam logic [31:0] MASKED_VALID = 32'h030B8951;

	// ==========================================================
	// Master control field positions and reset
	// ==========================================================
	localparam int CTL_CONT_BIT  = 0;
	localparam int CTL_START_BIT = 1;
	localparam int CTL_STOP_BIT  = 2;
	localparam int CTL_DMA_BIT   = 3;
	localparam logic [3:0] CTL_RESET = 4'h0;

	// ==========================================================
	// Event status bits
	// ==========================================================
	localparam int          EVT_W         = 2;
	localparam int          EVT_REFUSED   = 0; // Control write refused
	localparam int          EVT_DMA_CLR   = 1; // Master DMA enable cleared
	localparam logic [1:0]  EVT_RESET     = 2'h0;
	localparam logic [31:0] RDATA_RESET   = 32'h00000000;

	// Master control carrier
	typedef struct packed {
		logic dma;       // Master DMA enable
		logic stop;      // Master stop bit
		logic start;     // Master start bit
		logic cont;      // Master continue bit
	} master_ctl_t;

	// Bus-phase tracker, Gray coded
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ANSWER = 2'b01
	} apb_state_t;

endpackage

// file: i2c_irq_view_and_master_ctl.sv
// Functional notes
// [RULE1] Masked view is raw flag AND enable
// [RULE2] Monitor flags at bits 19, 17, 16
// [RULE3] Target flags at bits 15, 11, 8
// [RULE4] Master flags at bits 6, 4, 0
// [RULE5] Software writes zero to reserved bits
// [RULE6] Control writes only taken while master pending
// [RULE7] Software always writes a whole control value
// [RULE8] Start and stop bits never self-clear
// [RULE9] Software writes control only after pending
// [RULE10] DMA completion: clear DMA with start/stop
// [RULE11] Software sets DMA with or after continue
// [RULE12] Clearing DMA enable always accepted
// [RULE13] DMA enable requests DMA, auto-acknowledges receive
// [RULE14] Stop bit: stop, after NACK when receiving
// [RULE15] Masked view is read-only
module i2c_irq_view_and_master_ctl (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [i2c_ctl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [31:0]                 raw_status,
	input  wire logic [31:0]                 irq_enable,
	input  wire logic                        master_dma_done,
	input  wire logic                        master_data_req,
	input  wire logic                        master_rx_mode,
	output i2c_ctl_pkg::master_ctl_t         master_control,
	output logic                             master_dma_req,
	output logic                             master_auto_ack,
	output logic                             master_nack_stop,
	output logic                             irq
);

	import i2c_ctl_pkg::*;

	// ==========================================================
	// Declarations
	// ==========================================================
	apb_state_t   st_r;            // Bus phase
	apb_state_t   st_nxt;
	logic [31:0]  prdata_r;        // Read data register
	logic [31:0]  prdata_nxt;
	logic         pslverr_r;       // Error answer
	logic         pslverr_nxt;
	master_ctl_t  ctl_r;           // Master control register
	master_ctl_t  ctl_nxt;
	logic [EVT_W-1:0] evt_mask_r;  // Event mask register
	logic [EVT_W-1:0] evt_mask_nxt;
	logic [EVT_W-1:0] evt_sts;     // Sticky event flags
	logic [EVT_W-1:0] evt_set;     // Event pulses
	logic [EVT_W-1:0] evt_clr;     // Write-one-clear strobes
	logic         dma_req_r;       // Registered DMA request
	logic         auto_ack_r;      // Registered auto-acknowledge
	logic         nack_stop_r;     // Registered NACK-before-stop
	logic         irq_r;           // Registered interrupt
	logic         out_nxt_dma;
	logic         out_nxt_ack;
	logic         out_nxt_nack;
	logic         irq_nxt;
	logic [31:0]  masked_view;     // Combined masked status
	logic         xfer_done;       // Access phase completes
	logic         wr_done;         // Write completes this edge
	logic         mapped;          // Address decodes
	logic         full_ok;         // Whole control write allowed
	logic         ctl_wr;          // Write aimed at control
	logic         ctl_refused;     // Control write not taken

	// ==========================================================
	// Combined decode
	// ==========================================================
	// [RULE1] Flag AND enable
	// [RULE2] Monitor positions kept
	// [RULE3] Target positions kept
	// [RULE4] Master positions kept
	assign masked_view = raw_status & irq_enable & MASKED_VALID;

	// Transfer completes only when our ready is seen
	assign xfer_done = psel & penable & pready;
	assign wr_done   = xfer_done & pwrite;
	assign mapped    = (paddr == MASKED_STS_OFF) |
	                   (paddr == MASTER_CTL_OFF) |
	                   (paddr == EVT_STS_OFF) |
	                   (paddr == EVT_MASK_OFF);
	assign ctl_wr    = wr_done & (paddr == MASTER_CTL_OFF);

	// [RULE6] Pending gates whole write
	// [RULE10] DMA completion exception
	assign full_ok = raw_status[MST_PENDING_BIT] |
	                 (ctl_r.dma & master_dma_done &
	                  !pwdata[CTL_DMA_BIT]);

	assign ctl_refused = ctl_wr & !full_ok;

	// ==========================================================
	// Bus slave: phase tracker and read data
	// ==========================================================
	// Ready is raised for the first access cycle; read data is
	// sampled in the setup cycle so the flags may be one cycle old.
	always_comb begin
		st_nxt      = st_r;
		prdata_nxt  = prdata_r;
		pslverr_nxt = pslverr_r;
		unique case (st_r)
			ST_IDLE: begin
				if (psel && !penable) begin
					st_nxt      = ST_ANSWER;
					pslverr_nxt = !mapped;
					prdata_nxt  = RDATA_RESET;
					if (!pwrite) begin
						unique case (paddr)
							MASKED_STS_OFF: begin
								prdata_nxt = masked_view;
							end
							MASTER_CTL_OFF: begin
								prdata_nxt[3:0] = ctl_r;
							end
							EVT_STS_OFF: begin
								prdata_nxt[EVT_W-1:0] = evt_sts;
							end
							EVT_MASK_OFF: begin
								prdata_nxt[EVT_W-1:0] = evt_mask_r;
							end
							default: begin
								prdata_nxt = RDATA_RESET;
							end
						endcase
					end
				end
			end
			ST_ANSWER: begin
				// Single answer cycle, then back to idle
				st_nxt      = ST_IDLE;
				pslverr_nxt = 1'b0;
			end
		endcase
	end

	// Bus registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= ST_IDLE;
			prdata_r  <= RDATA_RESET;
			pslverr_r <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign pready  = (st_r == ST_ANSWER);
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	// ==========================================================
	// Master control register
	// ==========================================================
	// Start and stop hold their value; the sequencer must see a
	// fresh whole-value write to change them.
	always_comb begin
		ctl_nxt = ctl_r;
		if (ctl_wr) begin
			if (full_ok) begin
				// [RULE8] Bits held until rewritten
				ctl_nxt = master_ctl_t'(pwdata[3:0]);
			end else if (!pwdata[CTL_DMA_BIT]) begin
				// [RULE12] DMA clear always taken
				ctl_nxt.dma = 1'b0;
			end
		end
		// [RULE15] Masked view writes ignored
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= master_ctl_t'(CTL_RESET);
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	assign master_control = ctl_r;

	// ==========================================================
	// Sequencer-facing controls
	// ==========================================================
	always_comb begin
		// [RULE13] DMA request, auto acknowledge
		out_nxt_dma  = ctl_r.dma & master_data_req;
		out_nxt_ack  = ctl_r.dma & master_rx_mode;
		// [RULE14] NACK precedes receive stop
		out_nxt_nack = ctl_r.stop & master_rx_mode;
	end

	// Output registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_req_r   <= 1'b0;
			auto_ack_r  <= 1'b0;
			nack_stop_r <= 1'b0;
		end else begin
			dma_req_r   <= out_nxt_dma;
			auto_ack_r  <= out_nxt_ack;
			nack_stop_r <= out_nxt_nack;
		end
	end

	assign master_dma_req   = dma_req_r;
	assign master_auto_ack  = auto_ack_r;
	assign master_nack_stop = nack_stop_r;

	// ==========================================================
	// Events, mask and interrupt
	// ==========================================================
	always_comb begin
		evt_set              = '0;
		evt_set[EVT_REFUSED] = ctl_refused;
		evt_set[EVT_DMA_CLR] = ctl_wr & ctl_r.dma & !ctl_nxt.dma;
		evt_clr = '0;
		if (wr_done && paddr == EVT_STS_OFF) begin
			evt_clr = pwdata[EVT_W-1:0];
		end
		evt_mask_nxt = evt_mask_r;
		if (wr_done && paddr == EVT_MASK_OFF) begin
			evt_mask_nxt = pwdata[EVT_W-1:0];
		end
		irq_nxt = |(evt_sts & evt_mask_r);
	end

	// One sticky cell per event
	genvar gi;
	generate
		for (gi = 0; gi < EVT_W; gi++) begin : g_evt
			sticky_bit u_flag (
				.pclk    (pclk),
				.presetn (presetn),
				.set     (evt_set[gi]),
				.clr     (evt_clr[gi]),
				.q       (evt_sts[gi])
			);
		end
	endgenerate

	// Mask and interrupt registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_mask_r <= EVT_RESET;
			irq_r      <= 1'b0;
		end else begin
			evt_mask_r <= evt_mask_nxt;
			irq_r      <= irq_nxt;
		end
	end

	assign irq = irq_r;

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic rd_setup_masked; // Setup of a masked-view read
	assign rd_setup_masked = psel & !penable & !pwrite &
	                         (paddr == MASKED_STS_OFF) & (st_r == ST_IDLE);

	// [RULE1] Masked view check
	masked_read_a: assert property (rd_setup_masked |=> // [RULE1]
		prdata == ($past(raw_status) & $past(irq_enable) & MASKED_VALID))
		else $error("masked view differs from flags and enables");

	// [RULE2] Monitor idle position
	monitor_bits_a: assert property (rd_setup_masked |=> // [RULE2]
		prdata[MON_IDLE_BIT] == ($past(raw_status[MON_IDLE_BIT]) &
		$past(irq_enable[MON_IDLE_BIT])) && prdata[18] == 1'b0)
		else $error("monitor bits misplaced");

	// [RULE3] Target deselect position
	target_bits_a: assert property (rd_setup_masked |=> // [RULE3]
		prdata[TGT_DESEL_BIT] == ($past(raw_status[TGT_DESEL_BIT]) &
		$past(irq_enable[TGT_DESEL_BIT])))
		else $error("target bits misplaced");

	// [RULE4] Master pending position
	master_bits_a: assert property (rd_setup_masked |=> // [RULE4]
		prdata[MST_PENDING_BIT] == ($past(raw_status[MST_PENDING_BIT])
		& $past(irq_enable[MST_PENDING_BIT])) && prdata[3:1] == 3'h0)
		else $error("master bits misplaced");

	// [RULE6] Refused write keeps bits
	refused_write_a: assert property (ctl_refused |=> // [RULE6]
		$stable({ctl_r.start, ctl_r.stop, ctl_r.cont}) && evt_sts[0])
		else $error("control write taken while not pending");

	// [RULE8] Start holds
	start_held_a: assert property (ctl_r.start && !ctl_wr |=> // [RULE8]
		ctl_r.start)
		else $error("start bit cleared itself");

	// [RULE10] DMA done write
	dma_done_a: assert property (ctl_wr && ctl_r.dma && // [RULE10]
		master_dma_done && !pwdata[3] && pwdata[2] |=>
		ctl_r.stop && !ctl_r.dma)
		else $error("stop with DMA clear not taken");

	// [RULE12] DMA clear always
	dma_clear_a: assert property (ctl_wr && !pwdata[3] |=> // [RULE12]
		!ctl_r.dma)
		else $error("DMA enable clear refused");

	// [RULE13] DMA request path
	dma_req_a: assert property (ctl_r.dma && master_data_req |=> // [RULE13]
		master_dma_req ##0 !$past(master_rx_mode) || master_auto_ack)
		else $error("DMA request or auto ack missing");

	// [RULE14] NACK before stop
	nack_stop_a: assert property (ctl_r.stop && master_rx_mode |=> // [RULE14]
		master_nack_stop)
		else $error("no NACK before receive stop");

	// [RULE15] View write harmless
	view_ro_a: assert property (wr_done && paddr == MASKED_STS_OFF |=> // [RULE15]
		$stable(ctl_r) && $stable(evt_mask_r))
		else $error("write to masked view changed state");

	// Interrupt follows masked events
	irq_level_a: assert property (##1 irq == $past(|(evt_sts & evt_mask_r)))
		else $error("interrupt level wrong");

	refused_c:   cover property (ctl_refused);
	dma_stop_c:  cover property (ctl_wr && full_ok && !raw_status[0]);
	irq_c:       cover property (irq);
	masked_rd_c: cover property (rd_setup_masked ##1 prdata != 32'h0);

endmodule

// file: seq_model.sv
module seq_model
	import i2c_ctl_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] raw_in,
	input  wire logic        rx_in,
	input  wire logic        stall_in,
	input  master_ctl_t      master_control,
	input  wire logic        master_dma_req,
	output logic      [31:0] raw_status,
	output logic             master_dma_done,
	output logic             master_data_req,
	output logic             master_rx_mode
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Sequencer stand-in
	// ==========================================================
	logic [1:0] byte_cnt_r; // Bytes moved by DMA, capped at three

	// Count served requests; a cleared enable restarts the transfer
	// DMA bytes served
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_cnt_r <= 2'h0;
		end else if (!master_control.dma) begin
			byte_cnt_r <= 2'h0;
		end else if (master_dma_req && byte_cnt_r != 2'h3) begin
			byte_cnt_r <= byte_cnt_r + 2'h1;
		end
	end

	// Stall holds requests back, so the far side can be slow
	assign master_dma_done = master_control.dma && byte_cnt_r == 2'h3;
	assign master_data_req = master_control.dma && !master_dma_done
		&& !stall_in;
	assign master_rx_mode  = rx_in;

	// No pending flag once a DMA transfer has finished
	// DMA completion silent
	assign raw_status = master_dma_done ? {raw_in[31:1], 1'b0} : raw_in;
endmodule

// file: sticky_bit.sv
module sticky_bit (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);

	logic q_nxt; // Next flag value

	// ==========================================================
	// Next state: set beats a same-cycle clear
	// ==========================================================
	always_comb begin
		q_nxt = q;
		if (clr) begin
			q_nxt = 1'b0;
		end
		if (set) begin
			q_nxt = 1'b1;
		end
	end

	// Flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 1'b0;
		end else begin
			q <= q_nxt;
		end
	end

endmodule

// file: tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import i2c_ctl_pkg::*;

	// ==========================================================
	// Signals
	// ==========================================================
	typedef struct packed {
		logic [31:0] m;   // Bits compared
		logic [31:0] e;   // Expected read data
		logic        err; // Expected error answer
	} note_t;

	logic        pclk = 0, presetn = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, raw_in = 32'h0, irq_en = 32'h0;
	logic        rx_in = 0, stall_in = 0;
	logic [31:0] prdata, raw_status, rnd;
	logic        pready, pslverr, dma_done, data_req, rx_mode;
	logic        dma_req, auto_ack, nack_stop, irq;
	master_ctl_t ctl;
	note_t       notes[$]; // Expected read answers, oldest first
	note_t       nt;
	int          n_errors = 0, checks_done = 0, cyc = 0;
	logic        p_req = 0, p_ack = 0, p_stop = 0;
	int          bits[11] = '{CLK_LOW_TMO_BIT, EVENT_TMO_BIT, MON_IDLE_BIT,
		MON_OVERRUN_BIT, MON_READY_BIT, TGT_DESEL_BIT, TGT_NOSTRETCH_BIT,
		TGT_PENDING_BIT, MST_SS_ERR_BIT, MST_ARB_LOSS_BIT, MST_PENDING_BIT};

	always #5 pclk = ~pclk;

	i2c_irq_view_and_master_ctl DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .raw_status(raw_status), .irq_enable(irq_en),
		.master_dma_done(dma_done), .master_data_req(data_req),
		.master_rx_mode(rx_mode), .master_control(ctl),
		.master_dma_req(dma_req), .master_auto_ack(auto_ack),
		.master_nack_stop(nack_stop), .irq(irq));

	seq_model far_side (.pclk(pclk), .presetn(presetn), .raw_in(raw_in),
		.rx_in(rx_in), .stall_in(stall_in), .master_control(ctl),
		.master_dma_req(dma_req), .raw_status(raw_status),
		.master_dma_done(dma_done), .master_data_req(data_req),
		.master_rx_mode(rx_mode));

	// ==========================================================
	// Helpers
	// ==========================================================
	task close_out;
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Automatic: several watchers may call it in one time step
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (e !== g) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	// Galois shift register for random values
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return (s >> 1) ^ (s[0] ? 32'hA3000000 : 32'h00000000);
	endfunction

	// One APB transfer; held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 0;
		penable <= 0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic err);
		notes.push_back('{m, e, err});
		apb(0, a, 32'h0);
	endtask

	// Interrupt line settles one cycle after its cause
	task irq_chk(input logic e);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk("irq", e, irq);
	endtask

	// ==========================================================
	// Watchers
	// ==========================================================
	// Each completed read is matched to the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (notes.size() == 0) begin
				chk("read note", 32'h1, 32'h0);
			end else begin
				nt = notes.pop_front();
				chk("prdata", nt.e & nt.m, prdata & nt.m);
				chk("pslverr", nt.err, pslverr);
			end
		end
	end

	// Sequencer outputs follow their causes one cycle late
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_req = 0;
			p_ack = 0;
			p_stop = 0;
		end else begin
			chk("dma_req", p_req, dma_req);
			chk("auto_ack", p_ack, auto_ack);
			chk("nack_stop", p_stop, nack_stop);
			p_req = ctl.dma & data_req;
			p_ack = ctl.dma & rx_mode;
			p_stop = ctl.stop & rx_mode;
		end
	end

	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		raw_in <= 32'hFFFFFFFF;
		// Reset contents and an unmapped place
		rd(MASKED_STS_OFF, 32'h0, 32'hFFFFFFFF, 0);
		rd(MASTER_CTL_OFF, {28'h0, CTL_RESET}, 32'hFFFFFFFF, 0);
		rd(EVT_STS_OFF, 32'h0, 32'hFFFFFFFF, 0);
		rd(EVT_MASK_OFF, 32'h0, 32'hFFFFFFFF, 0);
		rd(12'h0FC, 32'h0, 32'hFFFFFFFF, 1);
		// Every flag position alone, both ways
		for (int i = 0; i < 11; i++) begin
			raw_in <= 32'hFFFFFFFF;
			irq_en <= 32'h1 << bits[i];
			rd(MASKED_STS_OFF, 32'h1 << bits[i], 32'hFFFFFFFF, 0);
			raw_in <= ~(32'h1 << bits[i]);
			irq_en <= 32'hFFFFFFFF;
			rd(MASKED_STS_OFF, MASKED_VALID & ~(32'h1 << bits[i]),
				32'hFFFFFFFF, 0);
		end
		// Random flags and enables
		rnd = 32'hB4453719;
		for (int i = 0; i < 8; i++) begin
			raw_in <= rnd;
			irq_en <= lfsr(rnd);
			rd(MASKED_STS_OFF, rnd & lfsr(rnd) & MASKED_VALID,
				32'hFFFFFFFF, 0);
			rnd = lfsr(lfsr(rnd));
		end
		// Writes to the view change nothing
		wr(MASKED_STS_OFF, 32'hFFFFFFFF);
		rd(MASKED_STS_OFF, raw_in & irq_en & MASKED_VALID,
			32'hFFFFFFFF, 0);
		// Control write while not pending is refused and flagged
		raw_in <= 32'h0;
		wr(MASTER_CTL_OFF, 32'h2);
		rd(MASTER_CTL_OFF, 32'h0, 32'hFFFFFFFF, 0);
		rd(EVT_STS_OFF, 32'h1, 32'h1, 0);
		wr(EVT_MASK_OFF, 32'h1);
		irq_chk(1);
		wr(EVT_MASK_OFF, 32'h0);
		irq_chk(0);
		wr(EVT_MASK_OFF, 32'h3);
		irq_chk(1);
		wr(EVT_STS_OFF, 32'h3);
		irq_chk(0);
		// The start bit keeps its value
		raw_in <= 32'h1;
		rx_in <= 1;
		wr(MASTER_CTL_OFF, 32'h2);
		raw_in <= 32'h0;
		repeat (20) @(posedge pclk);
		rd(MASTER_CTL_OFF, 32'h2, 32'hFFFFFFFF, 0);
		raw_in <= 32'h1;
		// Written only while pending, reserved bits zero
		wr(MASTER_CTL_OFF, 32'h4);
		rd(MASTER_CTL_OFF, 32'h4, 32'hFFFFFFFF, 0);
		// DMA transfer with a slow far side, then stop on completion
		stall_in <= 1;
		wr(MASTER_CTL_OFF, 32'h9);
		raw_in <= 32'h0;
		repeat (5) @(posedge pclk);
		stall_in <= 0;
		for (int i = 0; i < 50 && dma_done !== 1'b1; i++) @(posedge pclk);
		chk("dma_done", 1, dma_done);
		wr(MASTER_CTL_OFF, 32'h4);
		rd(MASTER_CTL_OFF, 32'h4, 32'hFFFFFFFF, 0);
		// Clearing DMA enable while not pending; transmit mode now,
		// so stop without NACK and DMA without auto acknowledge
		rx_in <= 0;
		wr(EVT_STS_OFF, 32'h3);
		raw_in <= 32'h1;
		stall_in <= 1;
		wr(MASTER_CTL_OFF, 32'h9);
		raw_in <= 32'h0;
		wr(MASTER_CTL_OFF, 32'h1);
		rd(MASTER_CTL_OFF, 32'h1, 32'hFFFFFFFF, 0);
		rd(EVT_STS_OFF, 32'h2, 32'h2, 0);
		irq_chk(1);
		repeat (3) @(posedge pclk);
		close_out();
	end
endmodule
